// ### src/sar_seq_pkg.sv
// shared constants and carrier types for the conversion sequencer
package sar_seq_pkg;
  // resolution and code points
  localparam int          RES_BITS      = 20;
  localparam logic [19:0] CODE_POS_FS   = 20'h7ffff;  // most positive code
  localparam logic [19:0] CODE_NEG_FS   = 20'h80000;  // most negative code
  localparam logic [19:0] CODE_MSB      = 20'h80000;  // first trial weight
  localparam logic [19:0] RESULT_RST    = 20'h00000;  // result after reset
  // internal conversion clock: one bit trial per period
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          TRIAL_NS      = 30;
  localparam int          TRIAL_CYCLES  = (TRIAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // flag reset value: no overvoltage seen
  localparam logic        FLAG_N_RST    = 1'b1;

  // front end toward the core: comparator and range detectors
  typedef struct packed {
    logic comp_high;   // input above current trial level
    logic over_fs;     // input above positive full scale
    logic under_fs;    // input below negative full scale
  } afe_in_t;

  // core toward the front end: hold switch, span and trial code
  typedef struct packed {
    logic        hold;       // high: sample held, arrays off the inputs
    logic        span_comp;  // high: reference scaled to 0.8
    logic [19:0] dac_code;   // offset-binary trial code for the array
  } afe_ctrl_t;
endpackage

// ### src/sync3.sv
// three-stage synchroniser with agreement filter on the last two stages
`timescale 1ns/1ps
module sync3 #(
  parameter logic RST_VAL = 1'b0  // level shown during reset
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // async level in, filtered level out
  input  wire logic d_async,
  output logic      q
);
  logic s1;       // first stage, read by s2 only
  logic s2;       // second stage
  logic s3;       // third stage
  logic next_q;   // filtered level

  // accept a change only when stages two and three agree
  always_comb begin
    next_q = q;
    if (s2 == s3) begin
      next_q = s3;
    end
  end

  // register the chain
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      q  <= RST_VAL;
    end else begin
      s1 <= d_async;
      s2 <= s1;
      s3 <= s2;
      q  <= next_q;
    end
  end
endmodule

// ### src/sar_conversion_sequencer.sv
// successive-approximation conversion sequencer with overvoltage flag
`timescale 1ns/1ps
module sar_conversion_sequencer
  import sar_seq_pkg::*;
#(
  parameter int TRIAL_CYC = TRIAL_CYCLES  // core clocks per bit trial
) (
  // clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RST_B,
  // host control pins
  input  wire logic       CONVERT_START,
  input  wire logic       SPAN_COMPRESS,
  input  wire logic       CFG_READ,
  // analog front end
  input  wire afe_in_t    AFE_IN,
  input  wire logic       CLAMP_ACTIVE,
  output afe_ctrl_t       AFE_CTRL,
  // results and status
  output logic [19:0]     RESULT,
  output logic            BUSY,
  output logic            DONE,
  output logic            OVERVOLTAGE_FLAG_N
);
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_ACQUIRE = 3'b001,
    ST_CONVERT = 3'b010,
    ST_FINISH  = 3'b100
  } seq_state_t;

  localparam int TICK_W = $clog2(TRIAL_CYC + 1);

  seq_state_t        state, next_state;       // sequencer state
  logic [4:0]        bit_idx, next_bit_idx;   // weight under trial
  logic [TICK_W-1:0] tick, next_tick;         // internal conversion clock
  logic [19:0]       sar, next_sar;           // kept bits, offset binary
  logic [19:0]       result, next_result;     // held output code
  logic              done, next_done;         // completion pulse
  logic              span_lat, next_span_lat; // span for this sample
  logic              flag_n, next_flag_n;     // sticky flag, active low
  logic              start_f;                 // filtered start level
  logic              start_d;                 // previous filtered level
  logic              clamp_f;                 // filtered clamp level
  logic              start_rise;              // start edge seen

  // trial code: kept bits plus the weight under test
  function automatic logic [19:0] trial_code(input logic [19:0] s, input logic [4:0] i);
    trial_code = s | (20'h00001 << i);
  endfunction

  // offset binary to two's complement with range saturation
  function automatic logic [19:0] to_code(input logic [19:0] s, input logic over,
                                          input logic under);
    if (over) begin
      to_code = CODE_POS_FS;
    end else if (under) begin
      to_code = CODE_NEG_FS;
    end else begin
      to_code = s ^ CODE_MSB;
    end
  endfunction

  // pin synchronisers
  sync3 #(.RST_VAL(1'b0)) u_start_sync (
    .clk     (CORE_CLK),
    .rst_b   (RST_B),
    .d_async (CONVERT_START),
    .q       (start_f)
  );
  sync3 #(.RST_VAL(1'b0)) u_clamp_sync (
    .clk     (CORE_CLK),
    .rst_b   (RST_B),
    .d_async (CLAMP_ACTIVE),
    .q       (clamp_f)
  );

  assign start_rise = start_f && !start_d;

  // conversion sequencer next state
  always_comb begin
    next_state    = state;
    next_bit_idx  = bit_idx;
    next_tick     = tick;
    next_sar      = sar;
    next_result   = result;
    next_done     = 1'b0;
    next_span_lat = span_lat;
    unique case (state)
      // tracking the input; edges elsewhere are ignored
      ST_ACQUIRE: begin
        if (start_rise) begin
          next_state    = ST_CONVERT;
          next_sar      = '0;          // fresh search, no old data
          next_bit_idx  = 5'(RES_BITS - 1);  // MSB first
          next_tick     = TICK_W'(TRIAL_CYC - 1);
          next_span_lat = SPAN_COMPRESS;
        end
      end
      // one trial per internal clock period
      ST_CONVERT: begin
        if (tick == '0) begin
          // keep the weight when the input is above the trial level
          if (AFE_IN.comp_high) begin
            next_sar = trial_code(sar, bit_idx);
          end
          next_tick = TICK_W'(TRIAL_CYC - 1);
          if (bit_idx == 5'd0) begin
            next_state = ST_FINISH;
          end else begin
            next_bit_idx = bit_idx - 5'd1;
          end
        end else begin
          next_tick = tick - TICK_W'(1);
        end
      end
      // form the code and flag completion
      ST_FINISH: begin
        next_result = to_code(sar, AFE_IN.over_fs, AFE_IN.under_fs);
        next_done   = 1'b1;
        next_state  = ST_ACQUIRE;
      end
    endcase
  end

  // overvoltage flag: set wins over read clear
  always_comb begin
    next_flag_n = flag_n;
    if (clamp_f) begin
      next_flag_n = 1'b0;
    end else if (CFG_READ) begin
      next_flag_n = 1'b1;  // read after condition ended
    end
  end

  // register all state
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      state    <= ST_ACQUIRE;
      bit_idx  <= 5'd0;
      tick     <= '0;
      sar      <= '0;
      result   <= RESULT_RST;
      done     <= 1'b0;
      span_lat <= 1'b0;
      flag_n   <= FLAG_N_RST;
      start_d  <= 1'b0;
    end else begin
      state    <= next_state;
      bit_idx  <= next_bit_idx;
      tick     <= next_tick;
      sar      <= next_sar;
      result   <= next_result;
      done     <= next_done;
      span_lat <= next_span_lat;
      flag_n   <= next_flag_n;
      start_d  <= start_f;
    end
  end

  // outputs
  assign AFE_CTRL.hold      = (state != ST_ACQUIRE);
  assign AFE_CTRL.span_comp = span_lat;
  assign AFE_CTRL.dac_code  = (state == ST_CONVERT) ? trial_code(sar, bit_idx) : sar;
  assign RESULT             = result;
  assign BUSY               = (state != ST_ACQUIRE);
  assign DONE               = done;
  assign OVERVOLTAGE_FLAG_N = flag_n;                 // host read only

  // checks
  // busy span follows the trial length this instance was built with
  localparam int CONV_LEN = RES_BITS * TRIAL_CYC + 1;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  sequence s_accept;
    state == ST_ACQUIRE && start_rise;
  endsequence

  sequence s_enter;
    state == ST_CONVERT && AFE_CTRL.hold && AFE_CTRL.dac_code == CODE_MSB;
  endsequence

  a_start_holds: assert property (s_accept |=> s_enter)
    else $error("start edge did not begin conversion");
  a_msb_first: assert property ($rose(BUSY) |-> AFE_CTRL.dac_code == CODE_MSB)
    else $error("first trial is not the MSB");
  a_trial_step: assert property (state == ST_CONVERT && tick == '0 && bit_idx != 5'd0
      |=> bit_idx == $past(bit_idx) - 5'd1 && tick == TICK_W'(TRIAL_CYC - 1))
    else $error("trial step wrong");
  a_conv_length: assert property (s_accept |=> BUSY ##CONV_LEN (DONE && !BUSY))
    else $error("conversion length wrong");
  a_code_map: assert property (state == ST_FINISH && !AFE_IN.over_fs && !AFE_IN.under_fs
      |=> RESULT == ($past(sar) ^ CODE_MSB))
    else $error("code not two's complement of search");
  a_sat_high: assert property (state == ST_FINISH && AFE_IN.over_fs
      |=> RESULT == CODE_POS_FS)
    else $error("overrange not saturated");
  a_sat_low: assert property (state == ST_FINISH && !AFE_IN.over_fs && AFE_IN.under_fs
      |=> RESULT == CODE_NEG_FS)
    else $error("underrange not saturated");
  a_span_stable: assert property (BUSY && $past(BUSY) |-> $stable(AFE_CTRL.span_comp))
    else $error("span changed mid conversion");
  a_flag_set: assert property (clamp_f |=> !OVERVOLTAGE_FLAG_N)
    else $error("clamp did not set flag");
  a_flag_sticky: assert property (!OVERVOLTAGE_FLAG_N && !(CFG_READ && !clamp_f)
      |=> !OVERVOLTAGE_FLAG_N)
    else $error("flag cleared without read");
  a_result_hold: assert property (!DONE |-> $stable(RESULT))
    else $error("result changed without completion");
endmodule

// ### verification/afe_model.sv
// front-end model: comparator and range detectors around a held sample
`timescale 1ns/1ps
module afe_model
  import sar_seq_pkg::*;
(
  // clock and control from the core
  input  wire logic               clk,
  input  wire afe_ctrl_t          ctrl,
  // sample in code units of the active span
  input  wire logic signed [31:0] vin,
  // decisions back to the core
  output afe_in_t                 afe
);
  logic junk = 1'b0;  // changing level while the array tracks the input

  // no stale decision outside a conversion
  always @(posedge clk) begin
    junk <= ~junk;
  end

  // decisions only valid on the held sample
  always_comb begin
    if (ctrl.hold) begin  // held sample against trial level
      afe.comp_high = (vin + 32'sh80000) >= int'(ctrl.dac_code);
      afe.over_fs   = vin > 32'sh7ffff;
      afe.under_fs  = vin < -32'sh80000;
    end else begin  // tracking: nothing to decide
      afe = {3{junk}};
    end
  end
endmodule

// ### verification/tb_sar_conversion_sequencer.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb_sar_conversion_sequencer
  import sar_seq_pkg::*;
;
  localparam int TC = 3;  // core clocks per bit trial
  // design pins
  logic        CORE_CLK;
  logic        RST_B;
  logic        CONVERT_START;
  logic        SPAN_COMPRESS;
  logic        CFG_READ;
  logic        CLAMP_ACTIVE;
  afe_in_t     AFE_IN;
  afe_ctrl_t   AFE_CTRL;
  logic [19:0] RESULT;
  logic        BUSY;
  logic        DONE;
  logic        OVERVOLTAGE_FLAG_N;
  // bench state
  int          vin;
  int          seed = 32'h0dfd6495;
  int          bad_count = 0;
  int          n_tests = 0;
  int          busy_len;
  logic [19:0] exp_q[$];
  logic [19:0] last_res;
  int          vals[7] = '{0, 1, -1, 32'sh7ffff, -32'sh80000, 32'sh80000, -32'sh80001};

  sar_conversion_sequencer #(.TRIAL_CYC(TC)) dut (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
    .CONVERT_START(CONVERT_START), .SPAN_COMPRESS(SPAN_COMPRESS), .CFG_READ(CFG_READ),
    .AFE_IN(AFE_IN), .CLAMP_ACTIVE(CLAMP_ACTIVE), .AFE_CTRL(AFE_CTRL), .RESULT(RESULT),
    .BUSY(BUSY), .DONE(DONE), .OVERVOLTAGE_FLAG_N(OVERVOLTAGE_FLAG_N));
  afe_model u_afe (.clk(CORE_CLK), .ctrl(AFE_CTRL), .vin(vin), .afe(AFE_IN));

  // 100 MHz clock
  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end

  // compare helpers
  task automatic cmp_code(string what, logic [19:0] e, logic [19:0] s);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic cmp_bit(string what, logic e, logic s);
    cmp_code(what, {19'h0, e}, {19'h0, s});
  endtask
  task automatic cmp_num(string what, int e, int s);
    cmp_code(what, e[19:0], s[19:0]);
  endtask

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // code expected for a sample
  function automatic logic [19:0] exp_code(int v);
    if (v > 32'sh7ffff) return CODE_POS_FS;
    if (v < -32'sh80000) return CODE_NEG_FS;
    return v[19:0];
  endfunction

  // one conversion, optionally with a refused start rise in mid-run
  task automatic convert(int v, logic sp, logic poke);
    int k;
    vin = v;
    SPAN_COMPRESS = sp;
    CONVERT_START = 1'b1;
    exp_q.push_back(exp_code(v));
    k = 0;
    while (BUSY !== 1'b1 && k < 20) begin
      @(negedge CORE_CLK);
      k++;
    end
    cmp_bit("hold", 1'b1, AFE_CTRL.hold);
    cmp_bit("span latched", sp, AFE_CTRL.span_comp);
    SPAN_COMPRESS = ~sp;
    if (poke) begin  // drop and raise start while busy
      repeat (8) @(negedge CORE_CLK);
      CONVERT_START = 1'b0;
      repeat (8) @(negedge CORE_CLK);
      CONVERT_START = 1'b1;
    end
    k = 0;
    while (DONE !== 1'b1 && k < 100) begin
      @(negedge CORE_CLK);
      k++;
    end
    CONVERT_START = 1'b0;
    repeat (8) @(negedge CORE_CLK);
  endtask

  // result watcher: pops the oldest note at each completion, looks between edges
  always @(negedge CORE_CLK) begin
    if (RST_B !== 1'b1) begin
      busy_len = 0;
      last_res = RESULT;
    end else begin
      if (BUSY === 1'b1) busy_len++;
      if (DONE === 1'b1) begin
        cmp_num("busy span", 20 * TC + 1, busy_len);
        busy_len = 0;
        if (exp_q.size() == 0) cmp_num("spare done", 0, 1);
        else cmp_code("result", exp_q.pop_front(), RESULT);
        last_res = RESULT;
      end else begin
        cmp_code("held result", last_res, RESULT);
      end
    end
  end

  // hang guard
  initial begin
    #60000;
    bad_count++;
    $display("watchdog expired");
    summarize();
  end

  // main sequence
  initial begin
    RST_B = 1'b0;
    CONVERT_START = 1'b0;
    SPAN_COMPRESS = 1'b0;
    CFG_READ = 1'b0;
    CLAMP_ACTIVE = 1'b0;
    vin = 0;
    repeat (12) @(negedge CORE_CLK);
    RST_B = 1'b1;
    repeat (3) @(negedge CORE_CLK);
    foreach (vals[i]) convert(vals[i], i[0], i == 3);
    $display("test code points done");
    repeat (10) begin
      vin = $random(seed) >>> 12;
      convert(vin, vin[0], 1'b0);
    end
    $display("test random samples done");
    cmp_bit("flag idle", 1'b1, OVERVOLTAGE_FLAG_N);
    CLAMP_ACTIVE = 1'b1;
    repeat (8) @(negedge CORE_CLK);
    cmp_bit("flag set", 1'b0, OVERVOLTAGE_FLAG_N);
    CFG_READ = 1'b1;
    @(negedge CORE_CLK);
    CFG_READ = 1'b0;
    repeat (2) @(negedge CORE_CLK);
    cmp_bit("read in clamp", 1'b0, OVERVOLTAGE_FLAG_N);
    CLAMP_ACTIVE = 1'b0;
    repeat (8) @(negedge CORE_CLK);
    cmp_bit("flag sticky", 1'b0, OVERVOLTAGE_FLAG_N);
    CFG_READ = 1'b1;
    @(negedge CORE_CLK);
    CFG_READ = 1'b0;
    repeat (2) @(negedge CORE_CLK);
    cmp_bit("flag cleared", 1'b1, OVERVOLTAGE_FLAG_N);
    $display("test overvoltage flag done");
    cmp_num("pending results", 0, exp_q.size());
    summarize();
  end
endmodule
